// >>> inc/uarx_map.svh
// Purpose: field codes, reset values and timing counts of the serial block
// Assumes: 40 MHz peripheral clock
// Notes: included by the design files, not by the package
`ifndef UARX_MAP_SVH
`define UARX_MAP_SVH

`define UARX_RECEIVE_MODE_FIELD_NORMAL 2'h0
`define UARX_RECEIVE_MODE_FIELD_DOUBLE 2'h1
`define UARX_RECEIVE_MODE_FIELD_GENERIC_AUTOBAUD_SETTING 2'h2
`define UARX_RECEIVE_MODE_FIELD_LIN_AUTOBAUD_SETTING 2'h3
`define UARX_OSR_NORMAL 5'h10
`define UARX_OSR_DOUBLE 5'h08
`define UARX_FIRST_NORMAL 5'h08
`define UARX_FIRST_DOUBLE 5'h04
`define UARX_BREAK_CYCLES 16'h000c
`define UARX_SYNC_BITS 4'h8
`define UARX_SYNC_CHAR 8'h55
`define UARX_BAUD_MIN 16'h0064
`define UARX_BAUD_RESET 16'h0040
`define UARX_DATA_BITS 4'h8

`endif

// >>> inc/uarx_pkg.sv
// Purpose: types shared by the serial block
// Assumes: nothing
// Notes: constants live in uarx_map.svh
package uarx_pkg;
    typedef enum logic [2:0]
    {
        UARX_RX_IDLE = 3'b000,
        UARX_RX_START = 3'b001,
        UARX_RX_DATA = 3'b010,
        UARX_RX_STOP = 3'b011
    } uarx_rx_state_t;
    typedef enum logic [1:0]
    {
        UARX_AB_BREAK = 2'b00,
        UARX_AB_WAIT_START = 2'b01,
        UARX_AB_MEASURE = 2'b10,
        UARX_AB_CHECK = 2'b11
    } uarx_ab_state_t;
    typedef enum logic [1:0]
    {
        UARX_TX_IDLE = 2'b00,
        UARX_TX_GUARD = 2'b01,
        UARX_TX_SHIFT = 2'b10
    } uarx_tx_state_t;
endpackage

// >>> verilog/uarx_tx.sv
// Purpose: transmitter with line-driver direction and pin drive control
// Assumes: i_tick is one pulse per bit time
// Notes: 8 data bits, one stop bit
`timescale 1ns/100ps
`include "uarx_map.svh"
module uarx_tx
    import uarx_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_tick,
    input wire logic i_start,
    input wire logic [7:0] i_data,
    input wire logic i_open_drain,
    input wire logic [1:0] i_line_driver_field,
    output logic o_busy,
    output logic o_tx_out,
    output logic o_tx_oe,
    output logic o_driver_direction_pin
);
    uarx_tx_state_t state_reg, state_next;
    logic [9:0] shift_reg, shift_next;
    logic [3:0] cnt_reg, cnt_next;
    logic dir_reg, dir_next;
    logic oe_reg, oe_next;
    logic out_reg, out_next;

    always_comb
    begin
        state_next = state_reg;
        shift_next = shift_reg;
        cnt_next = cnt_reg;
        dir_next = dir_reg;
        oe_next = oe_reg;
        out_next = out_reg;
        case (state_reg)
            UARX_TX_IDLE:
            begin
                out_next = 1'b1;
                if (i_start)
                begin
                    shift_next = {1'b1, i_data, 1'b0};
                    cnt_next = 4'h0;
                    state_next = UARX_TX_GUARD;
                end
            end
            UARX_TX_GUARD:
            begin
                // direction up one bit clock ahead
                dir_next = i_line_driver_field[0];
                oe_next = i_line_driver_field[1];
                // a whole bit tick passes with direction high before the start bit
                if (i_tick)
                begin
                    if (cnt_reg == 4'h0)
                        cnt_next = 4'h1;
                    else
                    begin
                        cnt_next = 4'h0;
                        state_next = UARX_TX_SHIFT;
                        out_next = shift_reg[0];
                    end
                end
            end
            UARX_TX_SHIFT:
            begin
                if (i_tick)
                begin
                    if (cnt_reg == 4'h9)
                    begin
                        dir_next = 1'b0;
                        oe_next = 1'b0;
                        out_next = 1'b1;
                        state_next = UARX_TX_IDLE;
                    end
                    else
                    begin
                        shift_next = {1'b1, shift_reg[9:1]};
                        out_next = shift_reg[1];
                        cnt_next = cnt_reg + 4'h1;
                    end
                end
            end
            default:
                state_next = UARX_TX_IDLE;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state_reg <= UARX_TX_IDLE;
            shift_reg <= 10'h3ff;
            cnt_reg <= 4'h0;
            dir_reg <= 1'b0;
            oe_reg <= 1'b0;
            out_reg <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
            shift_reg <= shift_next;
            cnt_reg <= cnt_next;
            dir_reg <= dir_next;
            oe_reg <= oe_next;
            out_reg <= out_next;
        end
    end

    assign o_busy = (state_reg != UARX_TX_IDLE);
    assign o_tx_out = i_open_drain ? 1'b0 : out_reg;
    assign o_tx_oe = i_open_drain ? ~out_reg :
        (oe_reg | ~i_line_driver_field[1]);
    assign o_driver_direction_pin = dir_reg;
endmodule

// >>> verilog/uarx_top.sv
// Purpose: asynchronous receiver with auto-baud, one-wire and line-driver control
// Assumes: 40 MHz clock, 8 data bits, no parity
// Notes: baud divisor counts peripheral clocks per bit time; sample rate is derived
// Notes on behaviour
// - receiver samples 16 per bit normally, 8 per bit in double speed.
// - first vote sample is 8 normal, 4 double speed.
// - middle vote sample is 9 normal, 5 double speed.
// - receive mode code 0x01 selects double speed.
// - double speed doubles baud for same divisor, halving samples.
// - each side stays within half the total baud error.
// - auto-baud break is 12 or more consecutive low cycles.
// - count clocks over eight sync bit times; result becomes divisor.
// - generic mode with wait-break accepts a break of any length.
// - generic mode loads divisor only when within 0x0064..0xffff.
// - LIN mode ignores wait-break; break needs 12 low clocks.
// - LIN sync char not 0x55 sets mismatch flag, baud kept; code checks only a byte strobed in the check cycle, before sync ends.
// - loopback connects transmit pin to receiver, detaching receive pin.
// - open drain transmitter only pulls the line low.
// - open drain makes the transmit pin an output only while it drives low.
// - one-wire receiver captures its own transmitted frames.
// - line-driver bit 0 drives direction high during transmission.
// - start bit accepted when two or three vote samples are low.
// - direction rises one bit clock early, stays high through stop.
// - line-driver bit 1 sets pin output one bit clock before transmission, except in open drain.
`timescale 1ns/100ps
`include "uarx_map.svh"
module uarx_top
    import uarx_pkg::*;
#(
    parameter int BAUD_W = 16
)
(
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_rx_pin,
    input wire logic i_tx_pin,
    input wire logic [1:0] i_receive_mode_field,
    input wire logic i_loopback_enable_bit,
    input wire logic i_open_drain_enable_bit,
    input wire logic [1:0] i_line_driver_field,
    input wire logic i_wait_break_bit,
    input wire logic i_sync_mismatch_clear,
    input wire logic [BAUD_W-1:0] i_baud_value,
    input wire logic i_baud_write,
    input wire logic i_tx_start,
    input wire logic [7:0] i_tx_data,
    output logic o_tx_busy,
    output logic o_tx_out,
    output logic o_tx_oe,
    output logic o_driver_direction_pin,
    output logic [7:0] o_rx_data,
    output logic o_rx_valid,
    output logic o_frame_error,
    output logic o_sync_mismatch_flag,
    output logic [BAUD_W-1:0] o_baud
);
    ////////////////////////////////////////////////////////////////////////////////
    logic rxp_s1_reg, rxp_s2_reg, txp_s1_reg, txp_s2_reg;
    logic line;
    uarx_rx_state_t rx_reg, rx_next;
    uarx_ab_state_t ab_reg, ab_next;
    logic [BAUD_W-1:0] baud_reg, baud_next;
    logic [BAUD_W-1:0] pre_reg, pre_next;
    logic [BAUD_W-1:0] bit_reg, bit_next;
    logic [4:0] samp_reg, samp_next;
    logic [1:0] votes_reg, votes_next;
    logic [3:0] bits_reg, bits_next;
    logic [7:0] data_reg, data_next;
    logic valid_reg, valid_next;
    logic ferr_reg, ferr_next;
    logic sync_err_reg, sync_err_next;
    logic [15:0] low_reg, low_next;
    logic [BAUD_W+3:0] meas_reg, meas_next;
    logic [3:0] edges_reg, edges_next;
    logic prev_reg, prev_next;
    logic tick, tx_tick, ab_on, dbl, brk_ok;
    logic [4:0] osr, first;

    // sample clock period = divisor / 16 in both speeds, so double speed halves the bit;
    // a divisor shorter than 16 clocks loses resolution
    function automatic logic [BAUD_W-1:0] sample_period(input logic [BAUD_W-1:0] b);
        sample_period = b >> 4;
        if (sample_period == '0)
            sample_period = {{(BAUD_W-1){1'b0}}, 1'b1};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // loopback takes the transmit pin, receive pin detached
    // own transmitted frames also seen here
    assign line = i_loopback_enable_bit ? txp_s2_reg : rxp_s2_reg;
    assign dbl = (i_receive_mode_field == `UARX_RECEIVE_MODE_FIELD_DOUBLE);
    assign ab_on = (i_receive_mode_field == `UARX_RECEIVE_MODE_FIELD_GENERIC_AUTOBAUD_SETTING) ||
        (i_receive_mode_field == `UARX_RECEIVE_MODE_FIELD_LIN_AUTOBAUD_SETTING);
    assign osr = dbl ? `UARX_OSR_DOUBLE : `UARX_OSR_NORMAL;
    assign first = dbl ? `UARX_FIRST_DOUBLE : `UARX_FIRST_NORMAL;
    // same divisor, same sample period count; half the samples per bit in double speed
    assign tick = (pre_reg == '0);
    assign tx_tick = (bit_reg == '0);

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        pre_next = tick ? sample_period(baud_reg) - 1'b1 : pre_reg - 1'b1;
        bit_next = tx_tick ? (dbl ? (baud_reg >> 1) : baud_reg) - 1'b1 : bit_reg - 1'b1;
        rx_next = rx_reg;
        samp_next = samp_reg;
        votes_next = votes_reg;
        bits_next = bits_reg;
        data_next = data_reg;
        valid_next = 1'b0;
        ferr_next = ferr_reg;
        if (tick)
        begin
            case (rx_reg)
                UARX_RX_IDLE:
                begin
                    if (!line)
                    begin
                        rx_next = UARX_RX_START;
                        samp_next = 5'h1;
                        votes_next = 2'h0;
                    end
                end
                UARX_RX_START, UARX_RX_DATA, UARX_RX_STOP:
                begin
                    samp_next = samp_reg + 5'h1;
                    // centred votes split the error margin
                    // three vote samples centred on the middle one
                    if (samp_reg >= first && samp_reg <= first + 5'h2 && !line)
                        votes_next = votes_reg + 2'h1;
                    if (samp_reg == first + 5'h2)
                    begin
                        if (rx_reg == UARX_RX_START)
                        begin
                            // two of three low accepts start
                            if (votes_next >= 2'h2)
                                rx_next = UARX_RX_DATA;
                            else
                                rx_next = UARX_RX_IDLE;
                            bits_next = 4'h0;
                        end
                        else if (rx_reg == UARX_RX_DATA)
                        begin
                            data_next = {(votes_next < 2'h2), data_reg[7:1]};
                            bits_next = bits_reg + 4'h1;
                        end
                        else
                        begin
                            // only the first stop bit is checked
                            ferr_next = (votes_next >= 2'h2);
                            valid_next = 1'b1;
                            rx_next = UARX_RX_IDLE;
                        end
                    end
                    if (samp_reg == osr && rx_reg != UARX_RX_IDLE)
                    begin
                        samp_next = 5'h1;
                        votes_next = 2'h0;
                        if (rx_reg == UARX_RX_DATA && bits_reg == `UARX_DATA_BITS)
                            rx_next = UARX_RX_STOP;
                    end
                end
                default:
                    rx_next = UARX_RX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        ab_next = ab_reg;
        baud_next = baud_reg;
        low_next = line ? 16'h0 : ((low_reg == 16'hffff) ? low_reg : low_reg + 16'h1);
        meas_next = meas_reg;
        edges_next = edges_reg;
        prev_next = line;
        sync_err_next = sync_err_reg & ~i_sync_mismatch_clear;
        // twelve low cycles; LIN never waives it
        // generic wait-break accepts any break length
        brk_ok = (low_reg >= `UARX_BREAK_CYCLES) ||
            (i_receive_mode_field == `UARX_RECEIVE_MODE_FIELD_GENERIC_AUTOBAUD_SETTING && i_wait_break_bit && !line);
        if (i_baud_write)
            baud_next = i_baud_value;
        if (!ab_on)
            ab_next = UARX_AB_BREAK;
        else
        begin
            case (ab_reg)
                UARX_AB_BREAK:
                    if (brk_ok)
                        ab_next = UARX_AB_WAIT_START;
                UARX_AB_WAIT_START:
                    // falling edge after the break ends is the sync start bit
                    if (prev_reg && !line)
                    begin
                        ab_next = UARX_AB_MEASURE;
                        meas_next = '0;
                        edges_next = 4'h0;
                    end
                UARX_AB_MEASURE:
                begin
                    // count clocks until the fifth falling edge = eight bits
                    meas_next = meas_reg + 1'b1;
                    if (prev_reg && !line)
                    begin
                        edges_next = edges_reg + 4'h1;
                        if (edges_reg == 4'h3)
                            ab_next = UARX_AB_CHECK;
                    end
                end
                UARX_AB_CHECK:
                begin
                    ab_next = UARX_AB_BREAK;
                    if (i_receive_mode_field == `UARX_RECEIVE_MODE_FIELD_LIN_AUTOBAUD_SETTING)
                    begin
                        // baud kept if a byte strobed in this cycle is not 0x55, or if the measured divisor is zero and CHECK repeats; the sync byte is still in flight
                        if (valid_reg && data_reg != `UARX_SYNC_CHAR)
                            sync_err_next = 1'b1;
                        else if (meas_reg[BAUD_W+2:3] != '0)
                            baud_next = meas_reg[BAUD_W+2:3];
                        else
                            ab_next = UARX_AB_CHECK;
                    end
                    else if (meas_reg[BAUD_W+3] == 1'b0 &&
                             meas_reg[BAUD_W+2:3] >= `UARX_BAUD_MIN)
                        baud_next = meas_reg[BAUD_W+2:3];
                end
                default:
                    ab_next = UARX_AB_BREAK;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rxp_s1_reg <= 1'b1;
            rxp_s2_reg <= 1'b1;
            txp_s1_reg <= 1'b1;
            txp_s2_reg <= 1'b1;
            rx_reg <= UARX_RX_IDLE;
            ab_reg <= UARX_AB_BREAK;
            baud_reg <= `UARX_BAUD_RESET;
            pre_reg <= '0;
            bit_reg <= '0;
            samp_reg <= 5'h0;
            votes_reg <= 2'h0;
            bits_reg <= 4'h0;
            data_reg <= 8'h00;
            valid_reg <= 1'b0;
            ferr_reg <= 1'b0;
            sync_err_reg <= 1'b0;
            low_reg <= 16'h0;
            meas_reg <= '0;
            edges_reg <= 4'h0;
            prev_reg <= 1'b1;
        end
        else
        begin
            rxp_s1_reg <= i_rx_pin;
            rxp_s2_reg <= rxp_s1_reg;
            txp_s1_reg <= i_tx_pin;
            txp_s2_reg <= txp_s1_reg;
            rx_reg <= rx_next;
            ab_reg <= ab_next;
            baud_reg <= baud_next;
            pre_reg <= pre_next;
            bit_reg <= bit_next;
            samp_reg <= samp_next;
            votes_reg <= votes_next;
            bits_reg <= bits_next;
            data_reg <= data_next;
            valid_reg <= valid_next;
            ferr_reg <= ferr_next;
            sync_err_reg <= sync_err_next;
            low_reg <= low_next;
            meas_reg <= meas_next;
            edges_reg <= edges_next;
            prev_reg <= prev_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    uarx_tx u_tx
    (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_tick(tx_tick),
        .i_start(i_tx_start),
        .i_data(i_tx_data),
        .i_open_drain(i_open_drain_enable_bit),
        .i_line_driver_field(i_line_driver_field),
        .o_busy(o_tx_busy),
        .o_tx_out(o_tx_out),
        .o_tx_oe(o_tx_oe),
        .o_driver_direction_pin(o_driver_direction_pin)
    );

    assign o_rx_data = data_reg;
    assign o_rx_valid = valid_reg;
    assign o_frame_error = ferr_reg;
    assign o_sync_mismatch_flag = sync_err_reg;
    assign o_baud = baud_reg;
endmodule

// >>> verif/uarx_top_sva.sv
// Purpose: port-level checks of the serial block
// Assumes: single clock domain, async active-low reset
// Notes: bound into uarx_top below the module
`timescale 1ns/100ps
module uarx_top_sva
#(
    parameter int BAUD_W = 16
)
(
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic [1:0] i_receive_mode_field,
    input wire logic i_open_drain_enable_bit,
    input wire logic [1:0] i_line_driver_field,
    input wire logic i_sync_mismatch_clear,
    input wire logic i_baud_write,
    input wire logic o_tx_busy,
    input wire logic o_tx_out,
    input wire logic o_tx_oe,
    input wire logic o_driver_direction_pin,
    input wire logic o_rx_valid,
    input wire logic o_sync_mismatch_flag,
    input wire logic [BAUD_W-1:0] o_baud
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    ////////////////////////////////////////////////////////////////////////////////
    a_od_never_high: assert property (
        i_open_drain_enable_bit && $past(i_open_drain_enable_bit) |-> !(o_tx_oe && o_tx_out))
        else $error("open drain pin driven high");
    a_dir_idle_low: assert property (
        !o_tx_busy && $past(!o_tx_busy) |-> !o_driver_direction_pin)
        else $error("direction pin high while idle");
    a_dir_field_off: assert property (
        !i_line_driver_field[0] && $past(!i_line_driver_field[0]) |-> !o_driver_direction_pin)
        else $error("direction pin high with control off");
    a_dir_whole_frame: assert property (
        i_line_driver_field[0] && $past(i_line_driver_field[0])
        && o_tx_busy && $past(o_tx_busy)
        |-> o_driver_direction_pin)
        else $error("direction pin low during a frame");
    a_dir_lead_start: assert property (
        i_line_driver_field[0] && !i_open_drain_enable_bit && o_tx_busy && $fell(o_tx_out)
        |-> $past(o_driver_direction_pin))
        else $error("direction pin not ahead of start bit");
    a_oe_lead_start: assert property (
        i_line_driver_field[1] && !i_open_drain_enable_bit && o_tx_busy && $fell(o_tx_out)
        |-> $past(o_tx_oe))
        else $error("pin not output ahead of start bit");
    a_rx_valid_gap: assert property (
        o_rx_valid |=> !o_rx_valid [*8])
        else $error("receive strobes too close");
    a_baud_only_write: assert property (
        i_receive_mode_field < 2'h2 && $past(i_receive_mode_field) < 2'h2
        && !$past(i_baud_write) |-> $stable(o_baud))
        else $error("divisor changed outside auto modes");
    a_generic_range: assert property (
        i_receive_mode_field == 2'h2 && !$past(i_baud_write) && !$stable(o_baud)
        |-> o_baud >= 16'h0064)
        else $error("divisor loaded out of range");
    a_mismatch_keeps: assert property (
        $rose(o_sync_mismatch_flag) |-> $stable(o_baud))
        else $error("divisor changed on sync mismatch");
    a_flag_sticky: assert property (
        o_sync_mismatch_flag && !i_sync_mismatch_clear |=> o_sync_mismatch_flag)
        else $error("mismatch flag dropped by itself");
endmodule

bind uarx_top uarx_top_sva #(.BAUD_W(BAUD_W)) u_sva (.i_clock(i_clock), .i_nrst(i_nrst),
    .i_receive_mode_field(i_receive_mode_field),
    .i_open_drain_enable_bit(i_open_drain_enable_bit),
    .i_line_driver_field(i_line_driver_field), .i_sync_mismatch_clear(i_sync_mismatch_clear),
    .i_baud_write(i_baud_write), .o_tx_busy(o_tx_busy), .o_tx_out(o_tx_out),
    .o_tx_oe(o_tx_oe), .o_driver_direction_pin(o_driver_direction_pin),
    .o_rx_valid(o_rx_valid), .o_sync_mismatch_flag(o_sync_mismatch_flag), .o_baud(o_baud));

// >>> verif/uarx_remote_node.sv
// Purpose: remote serial node and shared wire with pull-up
// Assumes: bit time given in peripheral clocks
// Notes: changes the line only on falling clock edges
`timescale 1ns/100ps
module uarx_remote_node
(
    input wire logic i_clock,
    input wire logic i_detach,
    input wire logic i_tx_out,
    input wire logic i_tx_oe,
    output logic o_rx_pin,
    output logic o_tx_wire
);
    logic line_reg = 1'b1;
    logic toggle_reg = 1'b0;
    ////////////////////////////////////////////////////////////////////////////////
    // a detached receive pin toggles, so a receiver still reading it is caught
    always @(negedge i_clock) toggle_reg <= ~toggle_reg;
    assign o_rx_pin = i_detach ? toggle_reg : line_reg;
    // pull-up wins unless the device drives
    assign o_tx_wire = (i_tx_oe === 1'b1) ? i_tx_out : 1'b1;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic level(input logic v, input int n);
        @(negedge i_clock);
        line_reg = v;
        repeat (n - 1) @(negedge i_clock);
    endtask
    // exact bit time, well inside the node's half of the error
    task automatic send(input logic [7:0] b, input int bt);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
            level(f[i], bt);
    endtask
endmodule

// >>> verif/uarx_top_test.sv
// Purpose: self-checking bench of the serial block
// Assumes: 40 MHz clock, divisor 0x0040 after reset
// Notes: expected bytes queue up; a monitor pops one per receive strobe outside auto modes
`timescale 1ns/100ps
module uarx_top_test;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic [1:0] mode = 2'h0;
    logic loopback = 1'b0;
    logic od = 1'b0;
    logic [1:0] ldf = 2'h0;
    logic wait_break = 1'b0;
    logic mm_clear = 1'b0;
    logic [15:0] baud_value = 16'h0000;
    logic baud_write = 1'b0;
    logic tx_start = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic rx_pin, tx_wire, tx_busy, tx_out, tx_oe, dir, rx_valid, frame_err, mm_flag;
    logic [7:0] rx_data;
    logic [15:0] baud;
    logic [15:0] mon_exp;
    logic [7:0] r = 8'h48;
    logic [15:0] exp_q[$];
    int miscompares = 0;
    int checked = 0;

    always #12.5 clock = ~clock;

    uarx_remote_node node (.i_clock(clock), .i_detach(loopback), .i_tx_out(tx_out),
        .i_tx_oe(tx_oe), .o_rx_pin(rx_pin), .o_tx_wire(tx_wire));

    uarx_top #(.BAUD_W(16)) uut (.i_clock(clock), .i_nrst(nrst), .i_rx_pin(rx_pin),
        .i_tx_pin(tx_wire), .i_receive_mode_field(mode), .i_loopback_enable_bit(loopback),
        .i_open_drain_enable_bit(od), .i_line_driver_field(ldf), .i_wait_break_bit(wait_break),
        .i_sync_mismatch_clear(mm_clear), .i_baud_value(baud_value), .i_baud_write(baud_write),
        .i_tx_start(tx_start), .i_tx_data(tx_data), .o_tx_busy(tx_busy), .o_tx_out(tx_out),
        .o_tx_oe(tx_oe), .o_driver_direction_pin(dir), .o_rx_data(rx_data),
        .o_rx_valid(rx_valid), .o_frame_error(frame_err), .o_sync_mismatch_flag(mm_flag),
        .o_baud(baud));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // bounded wait for the transmitter and for every queued byte
    task automatic settle();
        int n;
        n = 0;
        while ((tx_busy !== 1'b0 || exp_q.size() > 0) && n < 5000)
        begin
            @(negedge clock);
            n++;
        end
        if (n == 5000)
        begin
            miscompares++;
            $display("[ERR] %0t wait ran out", $time);
            test_done();
        end
    endtask

    task automatic send_tx(input logic [7:0] b);
        @(negedge clock);
        tx_data = b;
        tx_start = 1'b1;
        exp_q.push_back({8'h00, b});
        @(negedge clock);
        tx_start = 1'b0;
        settle();
    endtask

    // break of brk clocks, one idle bit, then the sync character
    task automatic autobaud(input int bt, input int brk);
        logic [1:0] m;
        m = mode;
        // one cycle outside auto modes returns the detector to break hunting
        mode = 2'h0;
        @(negedge clock);
        mode = m;
        node.level(1'b0, brk);
        node.level(1'b1, bt);
        node.send(8'h55, bt);
        repeat (2 * bt) @(negedge clock);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(negedge clock)
        if (rx_valid === 1'b1 && mode < 2'h2)
        begin
            mon_exp = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hffff;
            check({8'h00, rx_data}, mon_exp);
        end

    initial
    begin
        repeat (10) @(negedge clock);
        nrst = 1'b1;
        check(baud, 16'h0040);
        check({15'h0000, dir}, 16'h0000);
        $display("test reset done");
        for (int i = 0; i < 4; i++)
        begin
            r = lfsr(r);
            exp_q.push_back({8'h00, r});
            node.send(r, 64);
        end
        settle();
        check({15'h0000, frame_err}, 16'h0000);
        node.level(1'b0, 8);
        node.level(1'b1, 64);
        settle();
        $display("test normal receive done");
        mode = 2'h1;
        for (int i = 0; i < 2; i++)
        begin
            r = lfsr(r);
            exp_q.push_back({8'h00, r});
            node.send(r, 32);
        end
        settle();
        $display("test double speed done");
        mode = 2'h0;
        loopback = 1'b1;
        ldf = 2'h3;
        for (int i = 0; i < 2; i++)
        begin
            od = i[0];
            r = lfsr(r);
            send_tx(r);
        end
        loopback = 1'b0;
        od = 1'b0;
        ldf = 2'h0;
        $display("test one wire done");
        mode = 2'h2;
        autobaud(200, 3000);
        check(baud, 16'h00c8);
        wait_break = 1'b1;
        autobaud(120, 6);
        check(baud, 16'h0078);
        autobaud(50, 6);
        check(baud, 16'h0078);
        wait_break = 1'b0;
        $display("test generic auto done");
        mode = 2'h3;
        autobaud(150, 2250);
        check(baud, 16'h0096);
        check({15'h0000, mm_flag}, 16'h0000);
        mm_clear = 1'b1;
        baud_value = 16'h0040;
        baud_write = 1'b1;
        @(negedge clock);
        mm_clear = 1'b0;
        baud_write = 1'b0;
        mode = 2'h0;
        @(negedge clock);
        check(baud, 16'h0040);
        $display("test line auto done");
        test_done();
    end
endmodule
